/* rtl/nvm_table_consts.vh */
// constants for the table access and self-programming controller
// assumes a single 50 MHz clock and a 32-bit apb register bus
// Function
// - bit 7 picks program flash or eeprom
// - bit 6 picks configuration space over both
// - bit 4 makes next start a block erase
// - abort flag on reset abort or bad start
// - bit 2 permits or inhibits write cycles
// - bit 1 starts timed cycle, hardware clears
// - bit 0 eeprom read strobe, self clearing
// - bit 5 reads zero, writes ignored
// - abort keeps both space select bits
// - 8-bit latch holds each moved byte
// - 22-bit pointer from three byte registers
// - four pointer actions on low 21 bits
// - table read uses all 22 bits
// - table write fills holding register only
// - program write uses upper pointer bits
// - erase clears 64-byte block, bits 21:6
// - address lsb picks word high/low byte
// - erase/write only after unlock key sequence
// - core stalls until programming timer ends
// - erase always 64-byte block only
// - done flag set, cleared by firmware
// - holding bytes reset ffh, ffh skipped
// - key port reads all zeros
`ifndef NVM_TABLE_CONSTS_VH
`define NVM_TABLE_CONSTS_VH
// register byte offsets
`define OFS_CTRL    8'h00
`define OFS_KEY     8'h04
`define OFS_LATCH   8'h08
`define OFS_PTR_LO  8'h0c
`define OFS_PTR_HI  8'h10
`define OFS_PTR_UP  8'h14
`define OFS_TBL_OP  8'h18
`define OFS_STATUS  8'h1c
// control register bit positions
`define B_SPACE     7
`define B_CFG       6
`define B_ERASE     4
`define B_ABORT     3
`define B_PERMIT    2
`define B_START     1
`define B_READ      0
// table op command fields
`define B_OP_WRITE  2
// pointer update modes
`define PM_NONE     2'h0
`define PM_POSTINC  2'h1
`define PM_POSTDEC  2'h2
`define PM_PREINC   2'h3
// unlock key bytes
`define KEY_FIRST   8'h55
`define KEY_SECOND  8'haa
// blank holding byte
`define BLANK_BYTE  8'hff
// erase block offset width (64 bytes)
`define ERASE_BITS  6
// programming time and clock rate
`define PROG_TIME_US 2000
`define CLK_MHZ      50
`endif

/* rtl/nvm_table_ctrl.v */
// table access and self-programming controller for on-chip flash
// assumes an apb master on the core clock and a flash array port
// whose read data is valid one clock after the read strobe
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "nvm_table_consts.vh"

module nvm_table_ctrl #(
    parameter WB_BITS     = 4,    // log2 of write block bytes
    parameter PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
    input  wire        clock,      // core clock
    input  wire        nrst,       // power-on reset, low
    input  wire        warm_rst_n, // other device resets, async pin
    input  wire        psel,       // apb select
    input  wire        penable,    // apb access phase
    input  wire        pwrite,     // apb direction
    input  wire [7:0]  paddr,      // apb byte address
    input  wire [31:0] pwdata,     // apb write data
    output reg  [31:0] prdata,     // apb read data
    output reg         pready,     // apb ready
    output reg         pslverr,    // apb error, unmapped
    output reg  [21:0] flash_addr, // flash byte address
    output reg         flash_rd,   // flash word read strobe
    input  wire [15:0] flash_rdata,// flash word, next clock
    output reg         flash_wr,   // flash byte program strobe
    output reg  [7:0]  flash_wdata,// flash byte to program
    output reg         flash_erase,// 64-byte block erase strobe
    output reg  [1:0]  space_sel,  // {config, program} select
    output reg         ee_read,    // eeprom read strobe
    output reg         core_stall, // halts core during cycle
    output reg         done_flag   // completion flag
);

    localparam WB = 1 << WB_BITS;  // holding block bytes
    localparam S_IDLE = 2'h0;      // waiting
    localparam S_TRD  = 2'h1;      // table read data due
    localparam S_PROG = 2'h2;      // issuing block bytes
    localparam S_TIME = 2'h3;      // programming timer

    // two-flop synchroniser for the warm reset pin
    reg        wrst_s1_r;          // first stage
    reg        wrst_s2_r;          // second stage, usable

    // control bits
    reg        space_r;            // program flash select
    reg        cfg_r;              // configuration select
    reg        erase_r;            // block erase enable
    reg        abort_r;            // abort error flag
    reg        permit_r;           // write permit
    reg        start_r;            // cycle in progress
    reg        rd_r;               // eeprom read strobe bit

    reg  [7:0]  latch_r;           // table byte latch
    reg  [21:0] ptr_r;             // table pointer
    reg  [1:0]  key_r;             // unlock progress 0..2
    reg  [1:0]  state_r;           // sequencer state
    reg  [WB_BITS-1:0] idx_r;      // holding byte index
    reg  [31:0] tmr_r;             // programming timer
    reg         trd_lsb_r;         // byte select of pending read
    reg  [7:0]  hold_r [0:WB-1];   // write block holding bytes

    // apb decode; a transfer completes when pready is sampled high
    wire acc    = psel & penable;
    wire done   = acc & pready;
    wire wr_en  = done & pwrite;
    wire busy   = (state_r != S_IDLE);
    wire mapped = (paddr[1:0] == 2'h0) & (paddr <= `OFS_STATUS);

    wire [7:0] wb = pwdata[7:0];   // written byte

    // pointer arithmetic on the low 21 bits only
    wire [20:0] ptr_inc = ptr_r[20:0] + 21'h1;
    wire [20:0] ptr_dec = ptr_r[20:0] - 21'h1;
    wire [1:0]  op_mode = pwdata[1:0];
    wire        op_wr   = pwdata[`B_OP_WRITE];
    wire [21:0] eff_ptr = (op_mode == `PM_PREINC) ?
                          {ptr_r[21], ptr_inc} : ptr_r;
    reg  [21:0] ptr_after;         // pointer after this access

    // next pointer value for the four update modes
    always @* begin
        case (op_mode)
            `PM_NONE:    ptr_after = ptr_r;
            `PM_POSTINC: ptr_after = {ptr_r[21], ptr_inc};
            `PM_POSTDEC: ptr_after = {ptr_r[21], ptr_dec};
            default:     ptr_after = {ptr_r[21], ptr_inc};
        endcase
    end

    // command decode for writes
    wire w_ctrl  = wr_en & (paddr == `OFS_CTRL);
    wire w_key   = wr_en & (paddr == `OFS_KEY);
    wire w_op    = wr_en & (paddr == `OFS_TBL_OP);
    wire w_stat  = wr_en & (paddr == `OFS_STATUS);
    wire set_st  = w_ctrl & wb[`B_START] & ~start_r;
    // a start is good only straight after both key bytes, permitted
    wire good_st = set_st & (key_r == 2'h2) & permit_r;
    wire bad_st  = set_st & ~good_st;
    wire cyc_end = (state_r == S_TIME) &
                   (tmr_r == PROG_CYCLES - 1);
    wire warm    = ~wrst_s2_r;

    // synchronise the warm reset pin
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrst_s1_r <= 1'b1;
            wrst_s2_r <= 1'b1;
        end else begin
            wrst_s1_r <= warm_rst_n;
            wrst_s2_r <= wrst_s1_r;
        end
    end

    // apb handshake: one wait state, held off while the core stalls
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // stall every access while a cycle runs
            pready  <= acc & ~pready & ~busy & ~start_r;
            pslverr <= acc & ~pready & ~busy & ~start_r & ~mapped;
        end
    end

    // read data mux, captured with the ready
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0;
        end else if (acc & ~pready & ~pwrite) begin
            case (paddr)
                `OFS_CTRL:   prdata <= {24'h0, space_r, cfg_r, 1'b0,
                                        erase_r, abort_r, permit_r,
                                        start_r, rd_r};
                `OFS_KEY:    prdata <= 32'h0;
                `OFS_LATCH:  prdata <= {24'h0, latch_r};
                `OFS_PTR_LO: prdata <= {24'h0, ptr_r[7:0]};
                `OFS_PTR_HI: prdata <= {24'h0, ptr_r[15:8]};
                `OFS_PTR_UP: prdata <= {26'h0, ptr_r[21:16]};
                `OFS_STATUS: prdata <= {30'h0, busy, done_flag};
                default:     prdata <= 32'h0;
            endcase
        end
    end

    // unlock key tracker: any other write breaks the sequence
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            key_r <= 2'h0;
        end else if (w_key) begin
            if (wb == `KEY_FIRST)
                key_r <= 2'h1;
            else if (wb == `KEY_SECOND && key_r == 2'h1)
                key_r <= 2'h2;
            else
                key_r <= 2'h0;
        end else if (wr_en | warm) begin
            key_r <= 2'h0;
        end
    end

    // control register bits
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            space_r  <= 1'b0;
            cfg_r    <= 1'b0;
            erase_r  <= 1'b0;
            abort_r  <= 1'b0;
            permit_r <= 1'b0;
            start_r  <= 1'b0;
            rd_r     <= 1'b0;
        end else if (warm) begin
            // select bits survive so the failed access can be traced
            abort_r  <= abort_r | start_r;
            erase_r  <= 1'b0;
            permit_r <= 1'b0;
            start_r  <= 1'b0;
            rd_r     <= 1'b0;
        end else begin
            rd_r <= 1'b0;
            if (w_ctrl) begin
                space_r  <= wb[`B_SPACE];
                cfg_r    <= wb[`B_CFG];
                erase_r  <= wb[`B_ERASE];
                permit_r <= wb[`B_PERMIT];
                abort_r  <= wb[`B_ABORT] | bad_st;
                // read strobe refused for flash or config space
                rd_r <= wb[`B_READ] & ~wb[`B_SPACE] &
                        ~wb[`B_CFG];
            end
            if (good_st)
                start_r <= 1'b1;
            if (cyc_end) begin
                start_r <= 1'b0;
                erase_r <= 1'b0;
                abort_r <= 1'b0;
            end
        end
    end

    // completion flag: firmware clears by writing one, set wins
    always @(posedge clock or negedge nrst) begin
        if (!nrst)
            done_flag <= 1'b0;
        else if (cyc_end)
            done_flag <= 1'b1;
        else if (w_stat & wb[0])
            done_flag <= 1'b0;
    end

    // latch and pointer: software writes and table operations
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latch_r   <= 8'h0;
            ptr_r     <= 22'h0;
            trd_lsb_r <= 1'b0;
        end else begin
            if (wr_en & (paddr == `OFS_LATCH))
                latch_r <= wb;
            if (wr_en & (paddr == `OFS_PTR_LO))
                ptr_r[7:0] <= wb;
            if (wr_en & (paddr == `OFS_PTR_HI))
                ptr_r[15:8] <= wb;
            if (wr_en & (paddr == `OFS_PTR_UP))
                ptr_r[21:16] <= wb[5:0];
            if (w_op) begin
                ptr_r     <= ptr_after;
                trd_lsb_r <= eff_ptr[0];
            end
            // word lsb selects high or low byte into the latch
            if (state_r == S_TRD)
                latch_r <= trd_lsb_r ? flash_rdata[15:8] :
                                       flash_rdata[7:0];
        end
    end

    // holding registers: filled by table writes, blank after use
    integer i;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < WB; i = i + 1)
                hold_r[i] <= `BLANK_BYTE;
        end else if (cyc_end | warm) begin
            for (i = 0; i < WB; i = i + 1)
                hold_r[i] <= `BLANK_BYTE;
        end else if (w_op & op_wr) begin
            // only the low pointer bits matter here, flash untouched
            hold_r[eff_ptr[WB_BITS-1:0]] <= latch_r;
        end
    end

    // sequencer: table reads, block program, erase, timer
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r     <= S_IDLE;
            idx_r       <= {WB_BITS{1'b0}};
            tmr_r       <= 32'h0;
            flash_addr  <= 22'h0;
            flash_rd    <= 1'b0;
            flash_wr    <= 1'b0;
            flash_wdata <= 8'h0;
            flash_erase <= 1'b0;
        end else begin
            flash_rd    <= 1'b0;
            flash_wr    <= 1'b0;
            flash_erase <= 1'b0;
            if (warm) begin
                state_r <= S_IDLE;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        idx_r <= {WB_BITS{1'b0}};
                        tmr_r <= 32'h0;
                        if (w_op & ~op_wr) begin
                            flash_addr <= eff_ptr;
                            flash_rd   <= 1'b1;
                            state_r    <= S_TRD;
                        end else if (good_st & erase_r) begin
                            // low six bits cleared, block granular
                            flash_addr <= {ptr_r[21:`ERASE_BITS],
                                {`ERASE_BITS{1'b0}}};
                            flash_erase <= 1'b1;
                            state_r     <= S_TIME;
                        end else if (good_st) begin
                            state_r <= S_PROG;
                        end
                    end
                    S_TRD: begin
                        state_r <= S_IDLE;
                    end
                    S_PROG: begin
                        // blank bytes are skipped, flash keeps them
                        flash_addr <= {ptr_r[21:WB_BITS],
                                       idx_r};
                        flash_wdata <= hold_r[idx_r];
                        flash_wr    <= (hold_r[idx_r] !=
                                        `BLANK_BYTE);
                        idx_r <= idx_r + 1'b1;
                        if (idx_r == WB - 1)
                            state_r <= S_TIME;
                    end
                    S_TIME: begin
                        // the cycle ends by the timer, not by the array
                        tmr_r <= tmr_r + 32'h1;
                        if (cyc_end)
                            state_r <= S_IDLE;
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // registered copies of control state for the core side
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            space_sel  <= 2'h0;
            ee_read    <= 1'b0;
            core_stall <= 1'b0;
        end else begin
            space_sel  <= {cfg_r, space_r};
            ee_read    <= rd_r;
            // rise with the accepted start, so the erase pulse is covered
            core_stall <= (start_r | good_st) & ~cyc_end & ~warm;
        end
    end

endmodule // nvm_table_ctrl

/* sim/nvm_table_ctrl_chk.sv */
// port checks for the table access controller
// assumes the bind below and the shared register constants header
`include "nvm_table_consts.vh"
module nvm_table_ctrl_chk #(
    parameter int WB_BITS     = 4,  // log2 of block bytes
    parameter int PROG_CYCLES = 20  // programming timer length
) (
    input wire logic        clock,       // core clock
    input wire logic        nrst,        // power-on reset, low
    input wire logic        warm_rst_n,  // other resets, low
    input wire logic        psel,        // apb select
    input wire logic        penable,     // apb access phase
    input wire logic        pwrite,      // apb direction
    input wire logic [7:0]  paddr,       // apb address
    input wire logic [31:0] pwdata,      // apb write data
    input wire logic [31:0] prdata,      // apb read data
    input wire logic        pready,      // apb ready
    input wire logic [21:0] flash_addr,  // flash byte address
    input wire logic        flash_rd,    // flash read strobe
    input wire logic        flash_wr,    // flash program strobe
    input wire logic        flash_erase, // block erase strobe
    input wire logic        ee_read,     // eeprom read strobe
    input wire logic        core_stall,  // core halt level
    input wire logic        done_flag    // completion flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // longest legal stall: all bytes, the timer and some slack
    localparam int STALL_MAX = PROG_CYCLES + (1 << WB_BITS) + 8;
    logic [5:0] warm_hist;  // recent warm reset pin history
    wire        warm_quiet = &warm_hist;
    wire        status_clr = psel && penable && pwrite &&
                             paddr == `OFS_STATUS && pwdata[0];
    // the warm pin is synced late, so remember it for a few clocks
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) warm_hist <= 6'h3f;
        else warm_hist <= {warm_hist[4:0], warm_rst_n};
    end
    a_stall_blocks_ready: assert property (core_stall |-> !pready)
        else $error("ready given while core stalled");
    a_stall_timer_ends: assert property ($rose(core_stall) |->
        ##[1:STALL_MAX] !core_stall) else $error("stall too long");
    a_strobes_in_stall: assert property ((flash_wr || flash_erase)
        |-> core_stall && !flash_rd) else $error("array cycle unstalled");
    a_done_on_finish: assert property ($fell(core_stall) && warm_quiet
        |-> ##[0:2] done_flag) else $error("done flag not set");
    a_done_sticks: assert property (done_flag && !status_clr &&
        warm_quiet |=> done_flag) else $error("done flag dropped");
    a_key_reads_zero: assert property (psel && penable && pready &&
        !pwrite && paddr == `OFS_KEY |-> prdata == 32'h0)
        else $error("key port read nonzero");
    a_erase_block_base: assert property (flash_erase |->
        flash_addr[5:0] == 6'h00) else $error("erase not block aligned");
    a_erase_one_pulse: assert property (flash_erase |=>
        !flash_erase [*8]) else $error("erase repeated");
    a_read_one_pulse: assert property (flash_rd |=> !flash_rd)
        else $error("flash read strobe too long");
    a_ee_one_pulse: assert property (ee_read |=> !ee_read)
        else $error("eeprom strobe too long");
    c_erase: cover property (flash_erase);
    c_program: cover property (flash_wr ##[1:40] $fell(core_stall));
    c_ee_read: cover property (ee_read);
endmodule // nvm_table_ctrl_chk
bind nvm_table_ctrl nvm_table_ctrl_chk #(.WB_BITS(WB_BITS),
    .PROG_CYCLES(PROG_CYCLES)) i_nvm_table_ctrl_chk (.clock(clock),
    .nrst(nrst), .warm_rst_n(warm_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_wr(flash_wr), .flash_erase(flash_erase), .ee_read(ee_read),
    .core_stall(core_stall), .done_flag(done_flag));

/* sim/flash_array_model.sv */
// behavioural flash array behind the controller's array port
// assumes read data is wanted one clock after the read strobe
module flash_array_model (
    input  wire logic        clock,       // core clock
    input  wire logic [21:0] flash_addr,  // byte address
    input  wire logic        flash_rd,    // word read strobe
    output logic      [15:0] flash_rdata, // word data
    input  wire logic        flash_wr,    // byte program strobe
    input  wire logic [7:0]  flash_wdata, // byte to program
    input  wire logic        flash_erase  // block erase strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        rd_q = 1'b0;     // read seen last clock
    logic [21:0] addr_q;          // address of that read
    logic [15:0] junk = 16'h5a3c; // changes every clock when idle
    logic [29:0] wr_log[$];       // programmed {address, byte}
    logic [21:0] erase_log[$];    // erased addresses
    // word contents depend on the top pointer bit and word address
    function automatic logic [15:0] word_at(input logic [21:0] a);
        return {a[8:1] ^ {a[21], 7'h25}, a[8:1]};
    endfunction
    // log array activity; idle data keeps moving so stale reads show
    always @(posedge clock) begin
        rd_q <= flash_rd;
        addr_q <= flash_addr;
        junk <= ~junk ^ 16'h0101;
        if (flash_wr) wr_log.push_back({flash_addr, flash_wdata});
        if (flash_erase) erase_log.push_back(flash_addr);
    end
    assign flash_rdata = flash_rd ? word_at(flash_addr) :
                         rd_q ? word_at(addr_q) : junk;
endmodule // flash_array_model

/* sim/test_nvm_table_ctrl.sv */
// self-checking bench for the table access controller
// assumes the flash array model and the bound checker
`include "nvm_table_consts.vh"
module test_nvm_table_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [21:0] ptr, addr, nxt;  // start, read, end pointer
        logic [1:0]  mode;            // pointer update mode
    } row_t;
    logic        clock = 0, nrst = 0, warm_rst_n = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        pready, pslverr, err_q, flash_rd, flash_wr, flash_erase;
    logic        ee_read, core_stall, done_flag;
    logic [21:0] flash_addr;
    logic [15:0] flash_rdata;
    logic [7:0]  flash_wdata;
    logic [1:0]  space_sel;
    int          compares = 0, miscompares = 0, ee_cnt = 0;
    // wraps of the low 21 bits are the awkward rows
    row_t rows[5] = '{
        '{22'h000123, 22'h000123, 22'h000123, 2'h0},
        '{22'h000124, 22'h000124, 22'h000125, 2'h1},
        '{22'h000200, 22'h000200, 22'h0001ff, 2'h2},
        '{22'h3fffff, 22'h200000, 22'h200000, 2'h3},
        '{22'h200000, 22'h200000, 22'h3fffff, 2'h2}};
    nvm_table_ctrl #(.WB_BITS(4), .PROG_CYCLES(20)) i_nvm_table_ctrl (
        .clock(clock), .nrst(nrst), .warm_rst_n(warm_rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_rdata(flash_rdata), .flash_wr(flash_wr),
        .flash_wdata(flash_wdata), .flash_erase(flash_erase),
        .space_sel(space_sel), .ee_read(ee_read), .core_stall(core_stall),
        .done_flag(done_flag));
    flash_array_model i_flash_array_model (.clock(clock),
        .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_rdata(flash_rdata), .flash_wr(flash_wr),
        .flash_wdata(flash_wdata), .flash_erase(flash_erase));
    initial begin
        forever #10 clock = ~clock;
    end
    // count eeprom strobes as the design drives them
    always @(posedge clock) begin
        if (ee_read === 1'b1) ee_cnt++;
    end
    function automatic logic [7:0] byte_at(input logic [21:0] a);
        return a[0] ? a[8:1] ^ {a[21], 7'h25} : a[8:1];
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer, entered just after a rising edge; the long
    // bound covers an access that waits out a whole programming cycle
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 400);
        rd_q = prdata;
        err_q = pslverr;
        if (n >= 400) begin
            miscompares++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_chk(input string w, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(w, rd_q, exp);
    endtask
    task automatic set_ptr(input logic [21:0] p);
        apb(1'b1, `OFS_PTR_LO, {24'h0, p[7:0]});
        apb(1'b1, `OFS_PTR_HI, {24'h0, p[15:8]});
        apb(1'b1, `OFS_PTR_UP, {26'h0, p[21:16]});
    endtask
    task automatic unlock_start(input logic [7:0] c);
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_FIRST});
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_SECOND});
        apb(1'b1, `OFS_CTRL, {24'h0, c});
        // the start write itself is not held; this access waits the cycle
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("stall end", rd_q & 32'h2, 32'h0);
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        apb(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl reset", rd_q & 32'h37, 32'h0);
        foreach (rows[i]) begin
            set_ptr(rows[i].ptr);
            apb(1'b1, `OFS_TBL_OP, {30'h0, rows[i].mode});
            rd_chk("latch", `OFS_LATCH, {24'h0, byte_at(rows[i].addr)});
            rd_chk("ptr lo", `OFS_PTR_LO, {24'h0, rows[i].nxt[7:0]});
            rd_chk("ptr hi", `OFS_PTR_HI, {24'h0, rows[i].nxt[15:8]});
            rd_chk("ptr up", `OFS_PTR_UP, {26'h0, rows[i].nxt[21:16]});
        end
        apb(1'b1, `OFS_CTRL, 32'he4);
        rd_chk("ctrl", `OFS_CTRL, 32'hc4);
        check("space", {30'h0, space_sel}, 32'h3);
        apb(1'b1, `OFS_CTRL, 32'hc5);
        check("ee refused", ee_cnt, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'h01);
        rd_chk("ctrl rd", `OFS_CTRL, 32'h0);
        check("ee count", ee_cnt, 32'h1);
        check("space ee", {30'h0, space_sel}, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped err", {31'h0, err_q}, 32'h1);
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_FIRST});
        rd_chk("key", `OFS_KEY, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'h84);
        apb(1'b1, `OFS_CTRL, 32'h86);
        rd_chk("no key", `OFS_CTRL, 32'h8c);
        apb(1'b1, `OFS_CTRL, 32'h80);
        unlock_start(8'h82);
        apb(1'b0, `OFS_CTRL, 32'h0);
        check("no permit", rd_q & 32'h0a, 32'h08);
        apb(1'b1, `OFS_CTRL, 32'h94);
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_FIRST});
        apb(1'b1, `OFS_LATCH, 32'h11);
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_SECOND});
        apb(1'b1, `OFS_CTRL, 32'h96);
        apb(1'b0, `OFS_CTRL, 32'h0);
        check("broken key", rd_q & 32'h0a, 32'h08);
        check("no cycles", i_flash_array_model.erase_log.size() +
              i_flash_array_model.wr_log.size(), 32'h0);
        set_ptr(22'h0012ab);
        apb(1'b1, `OFS_CTRL, 32'h94);
        unlock_start(8'h96);
        check("erases", i_flash_array_model.erase_log.size(), 32'h1);
        check("erase addr", i_flash_array_model.erase_log[0], 32'h1280);
        check("erase writes", i_flash_array_model.wr_log.size(), 32'h0);
        rd_chk("ctrl erased", `OFS_CTRL, 32'h84);
        rd_chk("status", `OFS_STATUS, 32'h1);
        check("done pin", {31'h0, done_flag}, 32'h1);
        apb(1'b1, `OFS_STATUS, 32'h1);
        rd_chk("status clr", `OFS_STATUS, 32'h0);
        set_ptr(22'h001233);
        apb(1'b1, `OFS_LATCH, 32'h5a);
        apb(1'b1, `OFS_TBL_OP, 32'h5);
        apb(1'b1, `OFS_LATCH, 32'h6b);
        apb(1'b1, `OFS_TBL_OP, 32'h5);
        set_ptr(22'h0045f0);
        unlock_start(8'h86);
        check("writes", i_flash_array_model.wr_log.size(), 32'h2);
        check("wr 0", i_flash_array_model.wr_log[0], 32'h0045f35a);
        check("wr 1", i_flash_array_model.wr_log[1], 32'h0045f46b);
        rd_chk("ctrl wrote", `OFS_CTRL, 32'h84);
        unlock_start(8'h86);
        check("blank block", i_flash_array_model.wr_log.size(), 32'h2);
        apb(1'b1, `OFS_CTRL, 32'hd4);
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_FIRST});
        apb(1'b1, `OFS_KEY, {24'h0, `KEY_SECOND});
        fork
            apb(1'b1, `OFS_CTRL, 32'hd6);
            begin
                repeat (6) @(posedge clock);
                warm_rst_n <= 1'b0;
                repeat (3) @(posedge clock);
                warm_rst_n <= 1'b1;
            end
        join
        rd_chk("ctrl abort", `OFS_CTRL, 32'hc8);
        final_report();
    end
endmodule // test_nvm_table_ctrl
